// ### include/rps_params.svh
// Purpose: Constants for the remappable pin select block
// Assumes: APB, 32-bit data, word-aligned registers
// Notes: Offsets are byte addresses
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH
`define RPS_ISEL_W 4
`define RPS_OSEL_W 5
`define RPS_ADDR_W 12
`define RPS_OFF_SYSCFG 12'h000
`define RPS_OFF_DEVCFG 12'h004
`define RPS_OFF_STATUS 12'h008
`define RPS_OFF_ISEL_BASE 12'h100
`define RPS_OFF_OSEL_BASE 12'h200
`define RPS_LOCK_BIT 13
`define RPS_ONEWAY_BIT 29
`define RPS_UNLOCK_KEY1 32'hAA99_6655
`define RPS_UNLOCK_KEY2 32'h5566_99AA
`define RPS_OSEL_RST 5'h00
`define RPS_ISEL_RST 4'h0
`define RPS_ISEL_RES_A 4'h7
`define RPS_ISEL_LAST 4'hD
`define RPS_ISEL_SMALL_MAX 4'hA
`define RPS_OCODE_COUNT 32
`define RPS_GROUP_PINS 13
`endif

// ### include/rps_pkg.sv
// Purpose: Types for the remappable pin select block
// Assumes: Included constants header
// Notes: Unlock key sequence states
package rps_pkg;
  typedef enum logic [1:0] {
    RPS_KEY_IDLE,
    RPS_KEY_ONE,
    RPS_KEY_OPEN
  } rps_key_t;
endpackage

// ### core/rps_out_mux.sv
// Purpose: One output pin group: selector code to peripheral output
// Assumes: Peripheral outputs arrive as a flat vector indexed by code
// Notes: Code zero and reserved codes drive nothing
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"
module rps_out_mux #(
  parameter int NPINS = 13,
  parameter logic [31:0] VALID_MASK = 32'h0000_0000
) (
  input wire logic [NPINS*`RPS_OSEL_W-1:0] sel_i, // Selector per pin
  input wire logic [`RPS_OCODE_COUNT-1:0] periph_i, // Outputs by code
  output logic [NPINS-1:0] pin_o, // Pin value
  output logic [NPINS-1:0] drive_o // Pin owned by a peripheral
);
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic [`RPS_OSEL_W-1:0] code;
      assign code = sel_i[g*`RPS_OSEL_W +: `RPS_OSEL_W];
      assign drive_o[g] = VALID_MASK[code];
      assign pin_o[g] = VALID_MASK[code] & periph_i[code];
    end
  endgenerate
endmodule
`default_nettype wire

// ### core/rps_top.sv
// Purpose: Remappable pin select with APB register access
// Assumes: Peripheral signals synchronous to clk_sys_i
// Notes: Four output pin groups and one input group of peripheral inputs
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"

// Summary of operation
// - Each peripheral input has its own four-bit source pin selector.
// - Inputs of one group share one selector encoding.
// - Codes 0000 to 1100 except reserved 0111 pick one fixed remappable pin.
// - Small package lacks input codes 1011-1101 and some output selectors.
// - Each remappable pin has its own output selector register.
// - Output selector is bits 4:0 of the pin register.
// - Output selectors reset to zero, meaning no output drives.
// - Group one codes: uart1 transmit, spi1 data out, can1, encoder 1.
// - Group two codes: uart3 rts, uart4 transmit, compare 2, encoder 2.
// - Group three codes: uart3 transmit, reference clock 1, can3, encoder 3.
// - Group four codes: uart1 rts, uart2 transmit, charge pulse, encoder 4.
// - Locked selector writes complete normally but change nothing.
// - Mapping lock is bit 13 of system config register.
// - One-way option at bit 29 forbids clearing a set lock.
// - With one-way active only reset clears the lock.
// - One-way option is active by default.
// - Remapped peripheral beats other digital functions, not analog.
module rps_top
  import rps_pkg::*;
#(
  parameter int NPIN = `RPS_GROUP_PINS,
  parameter int NIN = 8,
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic clk_sys_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [`RPS_ADDR_W-1:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic [NPIN-1:0] pin_in_i, // Input group pin levels
  input wire logic [NIN-1:0] in_idle_i, // Inactive level per input
  output logic [NIN-1:0] periph_in_o, // Routed peripheral inputs
  input wire logic [4*`RPS_OCODE_COUNT-1:0] periph_out_i, // Outputs by code
  input wire logic [4*NPIN-1:0] analog_en_i, // Analog function on pin
  input wire logic [4*NPIN-1:0] gpio_i, // Other digital pin value
  output logic [4*NPIN-1:0] pin_out_o, // Pin output value
  output logic [4*NPIN-1:0] pin_remap_o // Peripheral owns pin
);
  localparam int NOUT = 4 * NPIN;
  localparam int OW = `RPS_OSEL_W;
  localparam int IW = `RPS_ISEL_W;
  // Valid code sets per output group, bit index is the code
  localparam logic [31:0] VM0 = 32'h0037_DBFE;
  localparam logic [31:0] VM1 = 32'h0037_DBFE;
  localparam logic [31:0] VM2 = 32'h0017_DFEE;
  localparam logic [31:0] VM3 = 32'h0017_DEF6;

  initial begin
    if (NPIN < 4 || NPIN > `RPS_GROUP_PINS) $error("NPIN out of range");
    if (NIN < 1 || NIN > 64) $error("NIN out of range");
  end

  typedef struct packed {
    logic lock;
    logic oneway;
    rps_key_t key;
    logic [NIN-1:0][IW-1:0] isel;
    logic [NOUT-1:0][OW-1:0] osel;
    logic [NIN-1:0] pin_in;
    logic [NOUT-1:0] pout;
    logic [NOUT-1:0] prem;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } rps_state_t;

  rps_state_t st_reg;
  rps_state_t st_next;
  logic [NOUT-1:0] mux_pin;
  logic [NOUT-1:0] mux_drv;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic isel_ok(input logic [IW-1:0] c);
    logic ok;
    ok = (c <= `RPS_ISEL_LAST) && (c != `RPS_ISEL_RES_A);
    // Codes past the last wired pin read as idle, never out of range
    if (int'(c) >= NPIN) begin
      ok = 1'b0;
    end
    // pins not bonded on the small package
    if (SMALL_PKG && c > `RPS_ISEL_SMALL_MAX) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic osel_present(input int idx);
    // last pins of each group absent on small package
    return !(SMALL_PKG && ((idx % NPIN) >= NPIN - 2));
  endfunction

  // ----------------------------------------
  // Output groups
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_grp
      rps_out_mux #(
        .NPINS(NPIN),
        .VALID_MASK(gi == 0 ? VM0 : gi == 1 ? VM1 : gi == 2 ? VM2 : VM3)
      ) u_mux (
        .sel_i(st_reg.osel[gi*NPIN +: NPIN]),
        .periph_i(periph_out_i[gi*`RPS_OCODE_COUNT +: `RPS_OCODE_COUNT]),
        .pin_o(mux_pin[gi*NPIN +: NPIN]),
        .drive_o(mux_drv[gi*NPIN +: NPIN])
      );
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic access;
    logic wr;
    logic [`RPS_ADDR_W-1:0] a;
    int ii;
    access = psel_i && !penable_i;
    wr = 1'b0;
    a = paddr_i;
    ii = 0;
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.err = 1'b0;

    // shared encoding, invalid code gives idle level
    for (int k = 0; k < NIN; k++) begin
      if (isel_ok(st_reg.isel[k])) begin
        st_next.pin_in[k] = pin_in_i[st_reg.isel[k]];
      end else begin
        st_next.pin_in[k] = in_idle_i[k];
      end
    end

    // remap beats gpio, analog beats remap
    for (int p = 0; p < NOUT; p++) begin
      st_next.prem[p] = mux_drv[p] && !analog_en_i[p];
      st_next.pout[p] = st_next.prem[p] ? mux_pin[p] : gpio_i[p];
    end

    // Answer one cycle after setup: pready high in first access cycle
    if (access) begin
      st_next.ready = 1'b1;
      wr = pwrite_i;
      st_next.rdata = 32'h0000_0000;
      if (a == `RPS_OFF_SYSCFG) begin
        if (wr) begin
          // lock moves only while the key is open
          if (st_reg.key == RPS_KEY_OPEN) begin
            // one-way refuses to clear a set lock
            if (!(st_reg.oneway && st_reg.lock && !pwdata_i[`RPS_LOCK_BIT])) begin
              st_next.lock = pwdata_i[`RPS_LOCK_BIT];
            end
          end
          st_next.key = RPS_KEY_IDLE;
        end
        st_next.rdata[`RPS_LOCK_BIT] = st_reg.lock;
      end else if (a == `RPS_OFF_DEVCFG) begin
        // One-way option is writable whenever the key is open and the lock is clear
        if (wr && st_reg.key == RPS_KEY_OPEN && !st_reg.lock) begin
          st_next.oneway = pwdata_i[`RPS_ONEWAY_BIT];
        end
        st_next.rdata[`RPS_ONEWAY_BIT] = st_reg.oneway;
      end else if (a == `RPS_OFF_STATUS) begin
        // Unlock sequence: two keys written back to back
        if (wr) begin
          unique case (st_reg.key)
            RPS_KEY_IDLE: begin
              if (pwdata_i == `RPS_UNLOCK_KEY1) st_next.key = RPS_KEY_ONE;
            end
            RPS_KEY_ONE: begin
              if (pwdata_i == `RPS_UNLOCK_KEY2) st_next.key = RPS_KEY_OPEN;
              else st_next.key = RPS_KEY_IDLE;
            end
            RPS_KEY_OPEN: begin
              st_next.key = RPS_KEY_OPEN;
            end
          endcase
        end
        st_next.rdata[1:0] = st_reg.key;
      end else if (a[`RPS_ADDR_W-1:8] == `RPS_OFF_ISEL_BASE >> 8) begin
        ii = int'(a[7:2]);
        if (a[1:0] != 2'b00 || ii >= NIN) begin
          st_next.err = 1'b1;
        end else begin
          // locked writes complete but are dropped
          if (wr && !st_reg.lock) begin
            st_next.isel[ii] = pwdata_i[IW-1:0];
          end
          st_next.rdata[IW-1:0] = st_reg.isel[ii];
        end
      end else if (a[`RPS_ADDR_W-1:8] == `RPS_OFF_OSEL_BASE >> 8) begin
        ii = int'(a[7:2]);
        if (a[1:0] != 2'b00 || ii >= NOUT || !osel_present(ii)) begin
          st_next.err = 1'b1;
        end else begin
          // per-pin selector, bits 4:0, lock gated
          if (wr && !st_reg.lock) begin
            st_next.osel[ii] = pwdata_i[OW-1:0];
          end
          st_next.rdata[OW-1:0] = st_reg.osel[ii];
        end
      end else begin
        st_next.err = 1'b1;
      end
      if (st_next.err) begin
        st_next.rdata = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.oneway <= 1'b1;
      st_reg.key <= RPS_KEY_IDLE;
      for (int r = 0; r < NOUT; r++) begin
        st_reg.osel[r] <= `RPS_OSEL_RST;
      end
      for (int r = 0; r < NIN; r++) begin
        st_reg.isel[r] <= `RPS_ISEL_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata_o = st_reg.rdata;
  assign pready_o = st_reg.ready;
  assign pslverr_o = st_reg.err;
  assign periph_in_o = st_reg.pin_in;
  assign pin_out_o = st_reg.pout;
  assign pin_remap_o = st_reg.prem;
endmodule
`default_nettype wire

// ### testbench/rps_top_assertions.sv
// Purpose: Port checks for the pin select block
// Assumes: APB answer in the cycle after setup
// Notes: Bound to every rps_top instance
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"
module rps_top_assertions #(
  parameter int NPIN = 13
) (
  input wire logic clk_sys_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic [`RPS_ADDR_W-1:0] paddr_i, // Address
  input wire logic pready_o, // Ready
  input wire logic pslverr_o, // Error
  input wire logic [4*NPIN-1:0] analog_en_i, // Analog use
  input wire logic [4*NPIN-1:0] gpio_i, // Other digital
  input wire logic [4*NPIN-1:0] pin_out_o, // Pin value
  input wire logic [4*NPIN-1:0] pin_remap_o // Pin owned
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  wire logic setup = psel_i && !penable_i;
  property p_answer; setup |=> pready_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_no_stray; !setup |=> !pready_o; endproperty
  a_no_stray: assert property (p_no_stray) else $error("ready without setup");
  property p_err_ready; pslverr_o |-> pready_o; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_cfg_ok; setup && paddr_i < 12'h00C |=> !pslverr_o; endproperty
  a_cfg_ok: assert property (p_cfg_ok) else $error("config access refused");
  property p_sel_ok;
    setup && paddr_i >= 12'h200 && paddr_i < 12'h200 + 16 * NPIN && paddr_i[1:0] == 2'b00
      |=> !pslverr_o;
  endproperty
  a_sel_ok: assert property (p_sel_ok) else $error("selector access refused");
  property p_unmapped; setup && paddr_i >= 12'h400 |=> pready_o && pslverr_o; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
  property p_reset_idle; $rose(arst_n_i) |-> pin_remap_o == '0; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pin owned after reset");
  property p_analog; $past(arst_n_i) |-> (pin_remap_o & $past(analog_en_i)) == '0; endproperty
  a_analog: assert property (p_analog) else $error("remap over analog pin");
  property p_gpio;
    $past(arst_n_i) |-> ((pin_out_o ^ $past(gpio_i)) & ~pin_remap_o) == '0;
  endproperty
  a_gpio: assert property (p_gpio) else $error("free pin lost digital value");
endmodule
bind rps_top rps_top_assertions #(.NPIN(NPIN)) u_rps_chk (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .analog_en_i(analog_en_i), .gpio_i(gpio_i), .pin_out_o(pin_out_o),
  .pin_remap_o(pin_remap_o));
`default_nettype wire

// ### testbench/rps_periph_model.sv
// Purpose: Peripherals and input pins beside the block
// Assumes: Static levels, mixed so a wrong code shows
// Notes: Some neighbouring codes share a level
`timescale 1ns/1ps
`default_nettype none
module rps_periph_model #(
  parameter int NPIN = 13
) (
  output logic [127:0] periph_out_o, // Outputs by code
  output logic [NPIN-1:0] pin_lvl_o // Input pin levels
);
  assign periph_out_o = 128'h96C3_5A0F_E13C_A569_3C96_0FA5_C35A_69E1;
  assign pin_lvl_o = NPIN'(13'h0B5B);
endmodule
`default_nettype wire

// ### testbench/rps_top_bench.sv
// Purpose: Self-checking bench for the pin select block
// Assumes: Wait-free APB slave
// Notes: Lock checks run just before the unmapped access check, then a reset clears them
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"
module rps_top_bench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`RPS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [51:0] analog_en = '0;
  logic [51:0] gpio = 52'hF_0F0F_3C3C_A5A5;
  logic [7:0] in_idle = 8'h5A;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  wire logic [12:0] pin_lvl;
  wire logic [7:0] periph_in;
  wire logic [127:0] periph_out;
  wire logic [51:0] pin_out, pin_remap;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int checked = 0;
  logic [4:0] ocode [16] = '{5'h01, 5'h03, 5'h0C, 5'h14, 5'h01, 5'h02, 5'h05, 5'h14,
                             5'h01, 5'h07, 5'h0C, 5'h14, 5'h01, 5'h02, 5'h12, 5'h14};
  logic [3:0] icode [6] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  always #2 clk_sys = ~clk_sys;
  rps_periph_model u_model (.periph_out_o(periph_out), .pin_lvl_o(pin_lvl));
  rps_top dut (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_lvl), .in_idle_i(in_idle),
    .periph_in_o(periph_in), .periph_out_i(periph_out), .analog_en_i(analog_en),
    .gpio_i(gpio), .pin_out_o(pin_out), .pin_remap_o(pin_remap));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic unl();
    apb(1'b1, `RPS_OFF_STATUS, `RPS_UNLOCK_KEY1);
    apb(1'b1, `RPS_OFF_STATUS, `RPS_UNLOCK_KEY2);
  endtask
  task automatic settle();
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    int g;
    int c;
    repeat (20) @(posedge clk_sys);
    chk(32'(|pin_remap), 0);
    arst_n <= 1'b1;
    apb(1'b0, `RPS_OFF_OSEL_BASE, 0);
    chk(rdat, 0);
    apb(1'b0, `RPS_OFF_DEVCFG, 0);
    chk(rdat[29], 1);
    for (int i = 0; i < 16; i++) begin
      g = i / 4;
      apb(1'b1, 12'h200 + 12'(g * 52), 32'(ocode[i]));
      settle();
      chk(pin_out[g*13], periph_out[g*32+ocode[i]]);
      chk(pin_remap[g*13], 1);
    end
    apb(1'b1, 12'h200, 32'hFFFF_FFEA);
    settle();
    chk(pin_remap[0], 0);
    apb(1'b0, 12'h200, 0);
    chk(rdat, 32'h0000_000A);
    for (int i = 0; i < 6; i++) begin
      c = icode[i];
      apb(1'b1, 12'h100, 32'(icode[i]));
      apb(1'b1, 12'h104, 32'(icode[i]));
      settle();
      chk(periph_in[0], (c == 7 || c > 13) ? in_idle[0] : pin_lvl[c]);
      chk(periph_in[1], (c == 7 || c > 13) ? in_idle[1] : pin_lvl[c]);
    end
    apb(1'b1, 12'h200, 1);
    @(posedge clk_sys) analog_en[0] <= 1'b1;
    settle();
    chk(pin_remap[0], 0);
    chk(pin_out[0], gpio[0]);
    @(posedge clk_sys) analog_en <= '0;
    unl();
    apb(1'b1, `RPS_OFF_SYSCFG, 32'h0000_2000);
    apb(1'b0, `RPS_OFF_SYSCFG, 0);
    chk(rdat[`RPS_LOCK_BIT], 1);
    apb(1'b1, 12'h200, 32'h0000_0003);
    chk(rerr, 0);
    apb(1'b0, 12'h200, 0);
    chk(rdat, 1);
    apb(1'b1, `RPS_OFF_SYSCFG, 0);
    apb(1'b0, `RPS_OFF_SYSCFG, 0);
    chk(rdat[`RPS_LOCK_BIT], 1);
    unl();
    apb(1'b1, `RPS_OFF_SYSCFG, 0);
    apb(1'b0, `RPS_OFF_SYSCFG, 0);
    chk(rdat[`RPS_LOCK_BIT], 1);
    apb(1'b0, 12'h400, 0);
    chk(rerr, 1);
    @(posedge clk_sys) arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    apb(1'b0, `RPS_OFF_SYSCFG, 0);
    chk(rdat[`RPS_LOCK_BIT], 0);
    apb(1'b0, 12'h200, 0);
    chk(rdat, 0);
    test_done();
  end
  initial begin
    #40000;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
